//--- dv/isa_16bit_slave_port_test.sv
// Self-checking bench for the ISA slave port.
// Assumes the host model and checker compile first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
  $display("unexpected %0t got %h want %h", $time, a, e); end end
module isa_16bit_slave_port_test;
  logic        clock = 0, rst_n = 0, hit;
  wire  [15:1] address;
  wire  [15:0] data_in, data_out;
  wire  [1:0]  data_oe;
  wire         address_qualifier, io_read_strobe_n, io_write_strobe_n, byte_lane0_enable_n;
  wire         byte_lane1_enable_n, local_device_select_n, async_ready_out;
  int          bad_count, n_compared, cyc, n;
  logic [15:0] rd, m;
  logic [1:0]  oe, ln;
  logic [34:0] rows [9] = '{{1'h1,15'h180,3'h0,16'ha5c3}, {1'h1,15'h181,3'h0,16'h1234},
    {1'h1,15'h181,3'h2,16'hffee}, {1'h1,15'h180,3'h1,16'h77ff}, {1'h1,15'h180,3'h4,16'h0},
    {1'h0,15'h188,3'h0,16'h0}, {1'h0,15'h180,3'h0,16'h77c3}, {1'h0,15'h181,3'h2,16'h00ee},
    {1'h0,15'h180,3'h1,16'h7700}};
  always #2 clock = ~clock;
  isa_16bit_slave_port i_dut (
    .clock                 (clock),
    .rst_n                 (rst_n),
    .address               (address),
    .address_qualifier     (address_qualifier),
    .io_read_strobe_n      (io_read_strobe_n),
    .io_write_strobe_n     (io_write_strobe_n),
    .byte_lane0_enable_n   (byte_lane0_enable_n),
    .byte_lane1_enable_n   (byte_lane1_enable_n),
    .data_in               (data_in),
    .data_out              (data_out),
    .data_oe               (data_oe),
    .local_device_select_n (local_device_select_n),
    .async_ready_out       (async_ready_out)
  );
  isa_host_model i_host (
    .clock                 (clock),
    .async_ready_out       (async_ready_out),
    .data_out              (data_out),
    .data_oe               (data_oe),
    .address               (address),
    .data_in               (data_in),
    .address_qualifier     (address_qualifier),
    .io_read_strobe_n      (io_read_strobe_n),
    .io_write_strobe_n     (io_write_strobe_n),
    .byte_lane1_enable_n   (byte_lane1_enable_n),
    .byte_lane0_enable_n   (byte_lane0_enable_n)
  );
  task end_of_test;
    if (bad_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clock) if (++cyc == 3000) begin bad_count++; end_of_test; end
  initial begin
    repeat (16) @(posedge clock);
    #1 rst_n = 1'b1;
    `CHK({data_oe, data_out, async_ready_out}, 19'h1)
    foreach (rows[i]) begin
      i_host.access(rows[i], rd, oe, n);
      hit = !rows[i][18] && rows[i][33:22] == 12'h030;
      ln = (rows[i][34] || !hit) ? 2'h0 : ~rows[i][17:16];
      m = {{8{ln[1]}}, {8{ln[0]}}};
      `CHK(oe, ln)
      `CHK(rd & m, rows[i][15:0] & m)
      `CHK(n > 1, hit)
      `CHK(n < 30, 1'b1)
      `CHK(local_device_select_n, !hit)
    end
    // Reset mid-run: data and ready outputs fall back, stored words survive
    @(posedge clock) #1 rst_n = 1'b0;
    @(posedge clock) #1;
    `CHK({data_oe, data_out, async_ready_out}, 19'h1)
    rst_n = 1'b1;
    i_host.access(rows[6], rd, oe, n);
    `CHK(oe, 2'h3)
    `CHK(rd, 16'h77c3)
    end_of_test;
  end
endmodule // isa_16bit_slave_port_test
bind isa_16bit_slave_port isa_port_checker i_chk (
  .clock                 (clock),
  .rst_n                 (rst_n),
  .address_qualifier     (address_qualifier),
  .io_read_strobe_n      (io_read_strobe_n),
  .io_write_strobe_n     (io_write_strobe_n),
  .byte_lane0_enable_n   (byte_lane0_enable_n),
  .byte_lane1_enable_n   (byte_lane1_enable_n),
  .address               (address),
  .data_in               (data_in),
  .data_out              (data_out),
  .data_oe               (data_oe),
  .local_device_select_n (local_device_select_n),
  .async_ready_out       (async_ready_out)
);
`default_nettype wire

//--- dv/isa_host_model.sv
// Behavioural ISA host, one transfer per access call.
// Assumes the port answers within 30 cycles.
`timescale 1ns/1ps
`default_nettype none
module isa_host_model (
  input  wire logic        clock,
  input  wire logic        async_ready_out,
  input  wire logic [15:0] data_out,
  input  wire logic [1:0]  data_oe,
  output var  logic [15:1] address,
  output var  logic [15:0] data_in,
  output var  logic        address_qualifier,
  output var  logic        io_read_strobe_n,
  output var  logic        io_write_strobe_n,
  output var  logic        byte_lane1_enable_n,
  output var  logic        byte_lane0_enable_n
);
  // 16-bit host; no upper word lanes exist
  initial {address, data_in, address_qualifier, io_read_strobe_n, io_write_strobe_n,
    byte_lane1_enable_n, byte_lane0_enable_n} = {31'h0, 5'h1f};
  task automatic access(input logic [34:0] r, output logic [15:0] rd,
                        output logic [1:0] oe, output int n);
    n = 0;
    oe = 2'h0;
    @(posedge clock) #1;
    {address, address_qualifier, byte_lane1_enable_n, byte_lane0_enable_n, data_in} = r[33:0];
    @(posedge clock) #1;
    if (r[34]) io_write_strobe_n = 1'b0;
    else io_read_strobe_n = 1'b0;
    do begin
      @(posedge clock);
      oe |= data_oe;
      n++;
    end while (!async_ready_out && n < 30);
    // Released lanes show the inverse, never a stale value
    rd = data_out ^ ~{{8{data_oe[1]}}, {8{data_oe[0]}}};
    #1;
    {io_read_strobe_n, io_write_strobe_n} = 2'h3;
    repeat (4) @(posedge clock);
  endtask
endmodule // isa_host_model
`default_nettype wire

//--- dv/isa_port_checker.sv
// Pin-level assertions for the ISA slave port.
// Assumes it is bound to the port top module.
`timescale 1ns/1ps
`default_nettype none
module isa_port_checker (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        address_qualifier,
  input wire logic        io_read_strobe_n,
  input wire logic        io_write_strobe_n,
  input wire logic        byte_lane0_enable_n,
  input wire logic        byte_lane1_enable_n,
  input wire logic [15:1] address,
  input wire logic [15:0] data_in,
  input wire logic [15:0] data_out,
  input wire logic [1:0]  data_oe,
  input wire logic        local_device_select_n,
  input wire logic        async_ready_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire       hit = !address_qualifier && address[15:4] == 12'h030;
  wire       rd  = !io_read_strobe_n && hit;
  wire       stb = io_read_strobe_n && io_write_strobe_n;
  wire [1:0] ln  = ~{byte_lane1_enable_n, byte_lane0_enable_n};
  property p_sel; local_device_select_n == !hit; endproperty
  a_sel: assert property (p_sel) else $error("select wrong");
  property p_miss; local_device_select_n |-> async_ready_out && data_oe == 2'h0; endproperty
  a_miss: assert property (p_miss) else $error("miss answered");
  property p_lead; $fell(stb) && hit |-> !async_ready_out; endproperty
  a_lead: assert property (p_lead) else $error("no wait");
  property p_rel; !async_ready_out |-> ##[1:12] async_ready_out; endproperty
  a_rel: assert property (p_rel) else $error("ready stuck");
  property p_lane; |data_oe |-> data_oe == ln; endproperty
  a_lane: assert property (p_lane) else $error("lane wrong");
  property p_src; $rose(|data_oe) |-> $past(rd, 2); endproperty
  a_src: assert property (p_src) else $error("drive unasked");
  property p_wr; !io_write_strobe_n |-> data_oe == 2'h0; endproperty
  a_wr: assert property (p_wr) else $error("drive on write");
  property p_wide; $fell(io_read_strobe_n) && hit && ln == 2'h3 |-> ##[2:5] data_oe == 2'h3;
  endproperty
  a_wide: assert property (p_wide) else $error("not 16 bit");
  cover property (rd);
  cover property (!io_write_strobe_n && hit);
  cover property (!stb && !hit);
endmodule // isa_port_checker
`default_nettype wire

//--- hw/isa_16bit_slave_port.v
// 16-bit ISA I/O slave port: decode, strobes, byte lanes, ready stretch.
// Assumes host pins are asynchronous and, except on the select and ready paths, pass two flip-flops first.
`timescale 1ns/1ps
`default_nettype none
`include "isa_port_regs.vh"
module isa_16bit_slave_port #(
  parameter [`DEC_W-1:0]  DECODE_BASE = `DEC_BASE,
  parameter [`WAIT_W-1:0] WAIT_CYCLES = `WAIT_CYCLES
) (
  input  wire                clock,
  input  wire                rst_n,
  input  wire [`ADDR_W:1]    address,
  input  wire                address_qualifier,
  input  wire                io_read_strobe_n,
  input  wire                io_write_strobe_n,
  input  wire                byte_lane0_enable_n,
  input  wire                byte_lane1_enable_n,
  input  wire [`DATA_W-1:0]  data_in,
  output reg  [`DATA_W-1:0]  data_out,
  output reg  [1:0]          data_oe,
  output wire                local_device_select_n,
  output reg                 async_ready_out
);
  // Decode straight from the pins: the select cannot wait for a clock
  // Totem-pole output; the board adds the open-collector buffer
  wire                     hit;
  assign hit = (address[`DEC_HI+1:`DEC_LO+1] == DECODE_BASE) && !address_qualifier;
  assign local_device_select_n = !hit;

  // Control pins gathered so one loop synchronises them all
  localparam [`CTL_W-1:0]  SYNC_IDLE = `CTL_IDLE;
  wire [`CTL_W-1:0]        ctl_pin;
  wire [`CTL_W-1:0]        ctl_q;
  assign ctl_pin[`CTL_RD] = io_read_strobe_n;
  assign ctl_pin[`CTL_WR] = io_write_strobe_n;
  assign ctl_pin[`CTL_B0] = byte_lane0_enable_n;
  assign ctl_pin[`CTL_B1] = byte_lane1_enable_n;
  assign ctl_pin[`CTL_HT] = hit;

  // Each pin passes two flip-flops, reset to its idle level
  // Idle reset level keeps a false strobe edge out after reset
  genvar gi;
  generate
    for (gi = 0; gi < `CTL_W; gi = gi + 1) begin : g_sync
      reg [1:0] sync_q;
      always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          sync_q <= {2{SYNC_IDLE[gi]}};
        end else begin
          sync_q <= {sync_q[0], ctl_pin[gi]};
        end
      end
      assign ctl_q[gi] = sync_q[1];
    end
  endgenerate

  // Word index and write data take the same two-stage path
  // Host holds them steady around the strobe, so no skew reaches use
  reg  [`REG_W-1:0]        a_s1_q;
  reg  [`REG_W-1:0]        a_s2_q;
  reg  [`DATA_W-1:0]       d_s1_q;
  reg  [`DATA_W-1:0]       d_s2_q;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      a_s1_q <= {`REG_W{1'b0}};
      a_s2_q <= {`REG_W{1'b0}};
    end else begin
      a_s1_q <= address[`REG_W:1];
      a_s2_q <= a_s1_q;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      d_s1_q <= {`DATA_W{1'b0}};
      d_s2_q <= {`DATA_W{1'b0}};
    end else begin
      d_s1_q <= data_in;
      d_s2_q <= d_s1_q;
    end
  end

  // Strobes count only while the synchronised decode hits
  wire                     rd_act;
  wire                     wr_act;
  wire                     access_act;
  wire [`LANES-1:0]        lanes;
  assign rd_act     = !ctl_q[`CTL_RD] && ctl_q[`CTL_HT];
  assign wr_act     = !ctl_q[`CTL_WR] && ctl_q[`CTL_HT];
  assign access_act = rd_act || wr_act;
  assign lanes      = {!ctl_q[`CTL_B1], !ctl_q[`CTL_B0]};

  // Write data held while the strobe is low, stored once it rises
  // Last sample before the rise wins, so late data still lands
  reg  [`DATA_W-1:0]       wdata_q;
  reg                      wr_prev_q;
  reg  [`LANES-1:0]        wlanes_q;
  reg  [`REG_W-1:0]        waddr_q;
  wire                     wr_commit;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wdata_q   <= {`DATA_W{1'b0}};
      wr_prev_q <= 1'b0;
      wlanes_q  <= 2'h0;
      waddr_q   <= {`REG_W{1'b0}};
    end else begin
      wr_prev_q <= wr_act;
      if (wr_act) begin
        wdata_q  <= d_s2_q;
        wlanes_q <= lanes;
        waddr_q  <= a_s2_q;
      end
    end
  end
  assign wr_commit = wr_prev_q && !wr_act;

  // Store port is shared: a commit borrows the address for one cycle
  wire [`DATA_W-1:0]       rd_word;
  wire [`REG_W-1:0]        store_addr;
  assign store_addr = wr_commit ? waddr_q : a_s2_q;

  isa_reg_store #(
    .DEPTH_W   (`REG_W)
  ) store (
    .clock     (clock),
    .rst_n     (rst_n),
    .wr_en     (wr_commit),
    .wr_lanes  (wlanes_q),
    .addr      (store_addr),
    .wr_data   (wdata_q),
    .rd_data_q (rd_word)
  );

  // Ready stretch: count wait cycles once the strobe is seen
  // An early release drops back to idle without finishing the count
  localparam [1:0]         ST_IDLE = 2'h0;
  localparam [1:0]         ST_WAIT = 2'h1;
  localparam [1:0]         ST_DONE = 2'h2;
  reg  [1:0]               state_q;
  reg  [1:0]               state_d;
  reg  [`WAIT_W-1:0]       wait_q;
  reg  [`WAIT_W-1:0]       wait_d;

  always @* begin
    state_d = state_q;
    wait_d  = wait_q;
    case (state_q)
      ST_IDLE: begin
        wait_d = {`WAIT_W{1'b0}};
        if (access_act) begin
          state_d = ST_WAIT;
        end
      end

      ST_WAIT: begin
        if (!access_act) begin
          state_d = ST_IDLE;
        end else if (wait_q == WAIT_CYCLES) begin
          state_d = ST_DONE;
        end else begin
          wait_d = wait_q + 1'b1;
        end
      end

      ST_DONE: begin
        if (!access_act) begin
          state_d = ST_IDLE;
        end
      end

      default: begin
        state_d = ST_IDLE;
        wait_d  = {`WAIT_W{1'b0}};
      end
    endcase
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      wait_q  <= {`WAIT_W{1'b0}};
    end else begin
      state_q <= state_d;
      wait_q  <= wait_d;
    end
  end

  // Leading edge must pull ready low at once, so this path is unclocked
  wire                     strobe_pin;
  assign strobe_pin = hit && !(io_read_strobe_n && io_write_strobe_n);

  always @* begin
    async_ready_out = !(strobe_pin && (state_q != ST_DONE));
  end

  // Per lane: drive only when the read selects it
  wire [`LANES-1:0]        oe_d;
  wire [`DATA_W-1:0]       dout_d;
  generate
    for (gi = 0; gi < `LANES; gi = gi + 1) begin : g_lane
      assign oe_d[gi] = rd_act && lanes[gi];
      assign dout_d[gi*`LANE_BITS +: `LANE_BITS] = rd_word[gi*`LANE_BITS +: `LANE_BITS];
    end
  endgenerate

  // Read data registered; released lanes are floated by the pad
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= {`DATA_W{1'b0}};
      data_oe  <= 2'h0;
    end else begin
      data_out <= dout_d;
      data_oe  <= oe_d;
    end
  end
endmodule // isa_16bit_slave_port
`default_nettype wire

//--- hw/isa_port_regs.vh
// Constants for the 16-bit ISA slave port.
// Assumes inclusion by bare name from hw/ design files.
// Behaviour
// - Serve all accesses over 16-bit data path
// - Select low on address match, qualifier low
// - Ready low at strobe leading edge
// - Ready high on clock after condition
// - Byte enables pick lower, upper, both lanes
// - Unselected lane floats on read, ignored write
// - Respond only while address qualifier low
// - Capture write data at strobe trailing edge
`ifndef ISA_PORT_REGS_VH
`define ISA_PORT_REGS_VH
`define DATA_W        16
`define ADDR_W        15
`define DEC_HI        14
`define DEC_LO        3
`define DEC_W         12
`define DEC_BASE      12'h030
`define REG_W         3
`define LANE0_HI      7
`define LANE1_LO      8
`define WAIT_W        4
`define WAIT_CYCLES   4'h2
`define LANES         2
`define LANE_BITS     8
`define CTL_W         5
`define CTL_RD        0
`define CTL_WR        1
`define CTL_B0        2
`define CTL_B1        3
`define CTL_HT        4
`define CTL_IDLE      5'h0f
`endif

//--- hw/isa_reg_store.v
// Small register store: eight 16-bit words with per-lane write.
// Assumes one clock domain; read data registered.
`timescale 1ns/1ps
`default_nettype none
`include "isa_port_regs.vh"
module isa_reg_store #(
  parameter DEPTH_W = `REG_W
) (
  input  wire                clock,
  input  wire                rst_n,
  input  wire                wr_en,
  input  wire [1:0]          wr_lanes,
  input  wire [DEPTH_W-1:0]  addr,
  input  wire [`DATA_W-1:0]  wr_data,
  output reg  [`DATA_W-1:0]  rd_data_q
);
  reg [`DATA_W-1:0] mem [0:(1<<DEPTH_W)-1];
  always @(posedge clock) begin
    if (wr_en && wr_lanes[0])
      mem[addr][`LANE0_HI:0] <= wr_data[`LANE0_HI:0];
    if (wr_en && wr_lanes[1])
      mem[addr][`DATA_W-1:`LANE1_LO] <= wr_data[`DATA_W-1:`LANE1_LO];
  end
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      rd_data_q <= {`DATA_W{1'b0}};
    else
      rd_data_q <= mem[addr];
  end
endmodule // isa_reg_store
`default_nettype wire
